// ==== hw/laser_analog_control_port.sv ====
// Control logic behind the laser's discrete analog/TTL control port
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
module laser_analog_control_port #(
  parameter int unsigned SETTLE_CYC     = laser_port_pkg::ms_to_cyc(laser_port_pkg::SETTLE_MS),
  parameter int unsigned TOGGLE_MIN_CYC = laser_port_pkg::ms_to_cyc(laser_port_pkg::TOGGLE_MIN_MS),
  parameter int unsigned TOGGLE_MAX_CYC = laser_port_pkg::ms_to_cyc(laser_port_pkg::TOGGLE_MAX_MS),
  parameter int unsigned LONG_OFF_CYC   = laser_port_pkg::ms_to_cyc(laser_port_pkg::LONG_OFF_MS),
  parameter int unsigned LOCKOUT_CYC    = laser_port_pkg::ms_to_cyc(laser_port_pkg::ON_LOCKOUT_MS),
  parameter int unsigned WARMUP_CYC     = laser_port_pkg::ms_to_cyc(laser_port_pkg::WARMUP_MS)
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire laser_port_pkg::port_pins_t pins,
  input  wire logic                    tec_stable,
  input  wire logic                    interlock_closed,
  input  wire logic [11:0]             energy_adc,
  input  wire logic [11:0]             ext_current_code,
  output laser_port_pkg::oc_ind_t      ind_level,
  output laser_port_pkg::oc_ind_t      ind_oe_n,
  output logic                         power_on_lamp,
  output logic [11:0]                  diode_current,
  output logic                         qswitch_trig,
  output logic                         trig_sync_out,
  output logic                         opto_sync_out,
  output logic [11:0]                  energy_hold
);

  if (TOGGLE_MIN_CYC == 0 || TOGGLE_MIN_CYC >= TOGGLE_MAX_CYC || TOGGLE_MAX_CYC >= LONG_OFF_CYC ||
      SETTLE_CYC == 0 || WARMUP_CYC < 2 || LOCKOUT_CYC == 0) begin : g_bad_cfg
    $error("laser_analog_control_port: inconsistent timing parameters");
  end
  if (laser_port_pkg::OPTO_LATENCY_CYC * laser_port_pkg::CLK_PERIOD_NS < laser_port_pkg::OPTO_MIN_NS ||
      laser_port_pkg::OPTO_LATENCY_CYC * laser_port_pkg::CLK_PERIOD_NS > laser_port_pkg::OPTO_MAX_NS)
  begin : g_bad_opto
    $error("laser_analog_control_port: optical sync latency outside window");
  end

  typedef enum logic [1:0] {EM_OFF, EM_WARMUP, EM_ON} em_state_t;

  function automatic logic ctl_active(input logic raw, input logic pol_high);
    return pol_high ? raw : !raw;
  endfunction : ctl_active

  laser_port_pkg::port_pins_t sync1_reg;
  laser_port_pkg::port_pins_t sync2_reg;
  laser_port_pkg::port_pins_t sync3_reg;

  logic [3:0]  ctrl_reg;
  logic [31:0] rate_reg;
  logic [11:0] current_reg;
  em_state_t   em_state_reg;
  logic [31:0] warm_cnt_reg;
  logic        ext_src_reg;
  logic [31:0] settle_cnt_reg;
  logic [31:0] press_cnt_reg;
  logic        pwr_act_reg;
  logic        power_on_reg;
  logic [31:0] lockout_cnt_reg;
  logic [31:0] int_cnt_reg;
  logic [7:0]  gap_cnt_reg;
  logic        opto_dly_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  laser_port_pkg::oc_ind_t ind_oe_n_reg;
  logic        qswitch_reg;
  logic        trig_sync_reg;
  logic        opto_pin_reg;
  logic [11:0] diode_reg;
  logic [11:0] energy_reg;

  logic pol_high;
  logic emission_request;
  logic standby_act;
  logic ready_cond;
  logic emit_allowed;
  logic settled;
  logic pwr_act;
  logic long_hit;
  logic toggle_ok;
  logic ext_mode;
  logic int_fire;
  logic ext_edge;
  logic ext_ok;
  logic fire;
  logic opto_fire;

  // Two-stage synchronisers; the third stage only feeds edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign pol_high    = ctrl_reg[laser_port_pkg::CTRL_POL_BIT];
  assign standby_act = ctl_active(sync2_reg.standby_in, pol_high);
  // Serial emission bit stands in when the request line is not selected
  assign emission_request = (ctrl_reg[laser_port_pkg::CTRL_SRC_BIT] == 1'b0) ?
                            ctl_active(sync2_reg.emission_request, pol_high) :
                            ctrl_reg[laser_port_pkg::CTRL_SW_EMIT_BIT];
  assign ready_cond   = power_on_reg && tec_stable;
  assign emit_allowed = emission_request && ready_cond && interlock_closed;

  // Emission sequencing: indicator at once, optical output after warm-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      em_state_reg <= EM_OFF;
      warm_cnt_reg <= '0;
    end else begin
      unique case (em_state_reg)
        EM_OFF: begin
          warm_cnt_reg <= '0;
          if (emit_allowed) begin
            em_state_reg <= EM_WARMUP;
          end
        end
        EM_WARMUP: begin
          if (!emit_allowed) begin
            em_state_reg <= EM_OFF;
          end else if (warm_cnt_reg == WARMUP_CYC - 1) begin
            em_state_reg <= EM_ON;
          end else begin
            warm_cnt_reg <= warm_cnt_reg + 32'h1;
          end
        end
        EM_ON: begin
          if (!emit_allowed) begin
            em_state_reg <= EM_OFF;
          end
        end
      endcase
    end
  end

  // Source choice follows the pin only while idle, so a late change cannot upset the diode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_src_reg <= 1'b0;
    end else if (em_state_reg == EM_OFF) begin
      ext_src_reg <= ctl_active(sync2_reg.current_source_select, pol_high);
    end
  end

  // Power decoder, shared by remote input and front button
  assign settled   = (settle_cnt_reg == SETTLE_CYC);
  assign pwr_act   = settled && (sync2_reg.power_remote || sync2_reg.power_button);
  assign long_hit  = pwr_act && (press_cnt_reg == LONG_OFF_CYC - 1);
  // Short pulses and the unspecified gaps fall outside this window and do nothing
  assign toggle_ok = pwr_act_reg && !pwr_act &&
                     (press_cnt_reg > TOGGLE_MIN_CYC) && (press_cnt_reg < TOGGLE_MAX_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_reg <= '0;
    end else if (!settled) begin
      settle_cnt_reg <= settle_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press_cnt_reg <= '0;
      pwr_act_reg   <= 1'b0;
    end else begin
      pwr_act_reg <= pwr_act;
      if (!pwr_act) begin
        press_cnt_reg <= '0;
      end else if (press_cnt_reg != LONG_OFF_CYC) begin
        press_cnt_reg <= press_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_reg    <= 1'b0;
      lockout_cnt_reg <= '0;
    end else begin
      if (lockout_cnt_reg != 32'h0) begin
        lockout_cnt_reg <= lockout_cnt_reg - 32'h1;
      end
      if (long_hit) begin
        power_on_reg    <= 1'b0;
        lockout_cnt_reg <= '0;
      end else if (toggle_ok && !power_on_reg) begin
        power_on_reg    <= 1'b1;
        lockout_cnt_reg <= LOCKOUT_CYC;
      end else if (toggle_ok && lockout_cnt_reg == 32'h0) begin
        power_on_reg <= 1'b0;
      end
    end
  end

  // Q-switch triggering
  assign ext_mode = (rate_reg == 32'h0);
  assign int_fire = !ext_mode && (int_cnt_reg == rate_reg - 32'h1);
  assign ext_edge = ctrl_reg[laser_port_pkg::CTRL_EDGE_BIT] ?
                    (sync2_reg.external_trigger_in && !sync3_reg.external_trigger_in) :
                    (!sync2_reg.external_trigger_in && sync3_reg.external_trigger_in);
  assign ext_ok   = ext_edge && (gap_cnt_reg >= laser_port_pkg::TRIG_MIN_GAP_CYC);
  assign fire     = (em_state_reg == EM_ON) && !standby_act &&
                    (ext_mode ? ext_ok : int_fire);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt_reg <= '0;
    end else if (ext_mode || em_state_reg != EM_ON || int_fire) begin
      int_cnt_reg <= '0;
    end else begin
      int_cnt_reg <= int_cnt_reg + 32'h1;
    end
  end

  // Edges closer than the suppression spacing are dropped, not queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt_reg <= laser_port_pkg::TRIG_MIN_GAP_CYC;
    end else if (ext_ok) begin
      gap_cnt_reg <= '0;
    end else if (gap_cnt_reg < laser_port_pkg::TRIG_MIN_GAP_CYC) begin
      gap_cnt_reg <= gap_cnt_reg + 8'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qswitch_reg   <= 1'b0;
      trig_sync_reg <= 1'b0;
    end else begin
      qswitch_reg   <= fire;
      trig_sync_reg <= pol_high ? fire : !fire;
    end
  end

  // Energy sample taken on the edge that starts each Q-switch pulse, held until the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energy_reg <= '0;
    end else if (fire) begin
      energy_reg <= energy_adc;
    end
  end

  // Optical sync: extra stage lands the output inside the delay window
  assign opto_fire = sync2_reg.optical_detect && !sync3_reg.optical_detect &&
                     (energy_adc >= laser_port_pkg::OPTO_MIN_ENERGY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opto_dly_reg <= 1'b0;
      opto_pin_reg <= 1'b1;
    end else begin
      opto_dly_reg <= opto_fire;
      opto_pin_reg <= pol_high ? opto_dly_reg : !opto_dly_reg;
    end
  end

  // Diode drive; external code is already a linear fraction of maximum current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diode_reg <= '0;
    end else if (em_state_reg != EM_ON) begin
      diode_reg <= '0;
    end else if (standby_act) begin
      diode_reg <= laser_port_pkg::STANDBY_CURRENT;
    end else if (ext_src_reg) begin
      diode_reg <= ext_current_code;
    end else begin
      diode_reg <= current_reg;
    end
  end

  // Indicators: oe_n low turns the transistor on and pulls the pin low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_oe_n_reg <= '1;
    end else begin
      ind_oe_n_reg.emission                 <= (em_state_reg == EM_OFF) && !emit_allowed;
      ind_oe_n_reg.ready                    <= !ready_cond;
      ind_oe_n_reg.interlock_open_indicator <= interlock_closed;
    end
  end

  // APB slave: one wait state, response registered
  function automatic logic [32:0] reg_read(input logic [7:0] addr);
    logic [31:0] st;
    st = '0;
    st[laser_port_pkg::ST_POWER_BIT]    = power_on_reg;
    st[laser_port_pkg::ST_READY_BIT]    = ready_cond;
    st[laser_port_pkg::ST_EMIT_IND_BIT] = !ind_oe_n_reg.emission;
    st[laser_port_pkg::ST_EMITTING_BIT] = (em_state_reg == EM_ON);
    st[laser_port_pkg::ST_EXT_SRC_BIT]  = ext_src_reg;
    st[laser_port_pkg::ST_STANDBY_BIT]  = standby_act;
    st[laser_port_pkg::ST_ILK_BIT]      = interlock_closed;
    st[laser_port_pkg::ST_EXTERNAL_TRIGGER_IN_BIT] = ext_mode;
    st[laser_port_pkg::ST_LOCKOUT_BIT]  = (lockout_cnt_reg != 32'h0);
    case (addr)
      laser_port_pkg::REG_CTRL:    return {1'b0, 28'h0, ctrl_reg};
      laser_port_pkg::REG_RATE:    return {1'b0, rate_reg};
      laser_port_pkg::REG_CURRENT: return {1'b0, 20'h0, current_reg};
      laser_port_pkg::REG_STATUS:  return {1'b0, st};
      laser_port_pkg::REG_ENERGY:  return {1'b0, 20'h0, energy_reg};
      default:                     return {1'b1, 32'h0};
    endcase
  endfunction : reg_read

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      if (psel && penable && !pready_reg) begin
        {pslverr_reg, prdata_reg} <= reg_read(paddr);
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= laser_port_pkg::CTRL_RESET;
      rate_reg    <= laser_port_pkg::RATE_RESET;
      current_reg <= laser_port_pkg::CURRENT_RESET;
    end else if (psel && penable && pready_reg && pwrite) begin
      unique case (paddr)
        laser_port_pkg::REG_CTRL:    ctrl_reg    <= pwdata[3:0];
        laser_port_pkg::REG_RATE:    rate_reg    <= pwdata;
        laser_port_pkg::REG_CURRENT: current_reg <= pwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign ind_level     = '0;
  assign ind_oe_n      = ind_oe_n_reg;
  assign power_on_lamp = power_on_reg;
  assign diode_current = diode_reg;
  assign qswitch_trig  = qswitch_reg;
  assign trig_sync_out = trig_sync_reg;
  assign opto_sync_out = opto_pin_reg;
  assign energy_hold   = energy_reg;

  a_request_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (em_state_reg == EM_OFF && !emit_allowed) |=> em_state_reg == EM_OFF)
    else $error("emission started without request, ready and interlock");

  a_serial_blocks_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg[laser_port_pkg::CTRL_SRC_BIT] && !ctrl_reg[laser_port_pkg::CTRL_SW_EMIT_BIT]
     && em_state_reg == EM_OFF) |=> em_state_reg == EM_OFF)
    else $error("request line acted while serial source selected");

  a_emit_indicator: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(emit_allowed) |=> !ind_oe_n.emission)
    else $error("emission indicator late");

  a_warmup_length: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(em_state_reg == EM_ON) |-> $past(warm_cnt_reg) == WARMUP_CYC - 1)
    else $error("emission began before warm-up elapsed");

  a_ready_ind: assert property (@(posedge pclk) disable iff (!presetn)
    !(power_on_reg && tec_stable) |=> ind_oe_n.ready)
    else $error("ready indicator on while not stable");

  a_source_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (em_state_reg != EM_OFF) |=> $stable(ext_src_reg))
    else $error("current source changed during emission");

  a_settle_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !settled |=> !power_on_reg)
    else $error("power changed before settle time");

  a_lockout_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (power_on_reg && lockout_cnt_reg > 32'h1 && !long_hit) |=> power_on_reg)
    else $error("toggle pulse powered off during start-up lockout");

  a_ext_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_mode && ext_ok && em_state_reg == EM_ON && !standby_act)
    |=> qswitch_trig ##1 !qswitch_trig)
    else $error("external edge did not give exactly one Q-switch pulse");

  a_standby_blank: assert property (@(posedge pclk) disable iff (!presetn)
    standby_act |=> !qswitch_trig)
    else $error("Q-switch fired in standby");

  a_energy_refresh: assert property (@(posedge pclk) disable iff (!presetn)
    qswitch_reg |-> energy_hold == $past(energy_adc))
    else $error("energy hold not refreshed with the pulse");

  a_opto_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!opto_fire ##1 !pol_high) |=> opto_sync_out)
    else $error("optical sync pulsed without a qualified pulse");

endmodule : laser_analog_control_port

// ==== shared/laser_port_pkg.sv ====
// Shared constants, register map and pin carriers for the laser control port
package laser_port_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Pulse-length and timing figures in milliseconds
  localparam int unsigned SETTLE_MS      = 4000;
  localparam int unsigned TOGGLE_MIN_MS  = 800;
  localparam int unsigned TOGGLE_MAX_MS  = 1200;
  localparam int unsigned LONG_OFF_MS    = 4000;
  localparam int unsigned ON_LOCKOUT_MS  = 10000;
  localparam int unsigned WARMUP_MS      = 3000;

  // External trigger limits in kHz
  localparam int unsigned TRIG_MAX_KHZ      = 300;
  localparam int unsigned TRIG_SUPPRESS_KHZ = 600;
  localparam logic [7:0]  TRIG_MIN_GAP_CYC  = 8'((CLK_HZ / 1000) / TRIG_SUPPRESS_KHZ);

  // Optical sync delay window in ns, and the pipeline depth that sets it
  localparam int unsigned OPTO_MIN_NS      = 30;
  localparam int unsigned OPTO_MAX_NS      = 100;
  localparam int unsigned OPTO_LATENCY_CYC = 4;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_RATE    = 8'h04;
  localparam logic [7:0] REG_CURRENT = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_ENERGY  = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_SRC_BIT     = 0;
  localparam int unsigned CTRL_SW_EMIT_BIT = 1;
  localparam int unsigned CTRL_POL_BIT     = 2;
  localparam int unsigned CTRL_EDGE_BIT    = 3;
  localparam logic [3:0]  CTRL_RESET       = 4'h1;

  // Status register fields
  localparam int unsigned ST_POWER_BIT    = 0;
  localparam int unsigned ST_READY_BIT    = 1;
  localparam int unsigned ST_EMIT_IND_BIT = 2;
  localparam int unsigned ST_EMITTING_BIT = 3;
  localparam int unsigned ST_EXT_SRC_BIT  = 4;
  localparam int unsigned ST_STANDBY_BIT  = 5;
  localparam int unsigned ST_ILK_BIT      = 6;
  localparam int unsigned ST_EXTERNAL_TRIGGER_IN_BIT = 7;
  localparam int unsigned ST_LOCKOUT_BIT  = 8;

  localparam logic [31:0] RATE_RESET        = 32'h0000_03e8;
  localparam logic [11:0] CURRENT_RESET     = 12'h800;
  localparam logic [11:0] STANDBY_CURRENT   = 12'h0cd;
  localparam logic [11:0] ENERGY_NOMINAL    = 12'h7d0;
  localparam logic [11:0] OPTO_MIN_ENERGY   = 12'h064;

  function automatic int unsigned ms_to_cyc(input int unsigned ms);
    return ms * (CLK_HZ / 1000);
  endfunction : ms_to_cyc

  // Raw control-port inputs
  typedef struct packed {
    logic emission_request;
    logic power_remote;
    logic power_button;
    logic current_source_select;
    logic external_trigger_in;
    logic standby_in;
    logic optical_detect;
  } port_pins_t;

  // Open-collector indicators
  typedef struct packed {
    logic emission;
    logic ready;
    logic interlock_open_indicator;
  } oc_ind_t;

endpackage : laser_port_pkg

// ==== verification/port_controller_model.sv ====
// Behavioural external controller driving the control-port pins
`timescale 1ns/1ns
module port_controller_model (
  input  wire laser_port_pkg::oc_ind_t ind_oe_n,
  input  wire logic                    pclk,
  output laser_port_pkg::port_pins_t   pins
);
  int err_count = 0;
  initial pins = 7'h4e;
  task automatic power_pulse(input int unsigned n);
    @(posedge pclk);
    pins.power_remote <= 1'b1;
    repeat (n) @(posedge pclk);
    pins.power_remote <= 1'b0;
  endtask : power_pulse
  // Source select stays put; request once ready is reported, or after 100 cycles without it
  task automatic emit();
    int n;
    for (n = 0; n < 100 && ind_oe_n.ready !== 1'b0; n++) @(posedge pclk);
    pins.emission_request <= 1'b0;
    // No prompt emission indication means an internal fault
    for (n = 0; n < 10 && ind_oe_n.emission !== 1'b0; n++) @(posedge pclk);
    if (ind_oe_n.emission !== 1'b0) err_count++;
  endtask : emit
  // Period of 2p cycles; p = 200 gives 250 kHz
  task automatic trig_edges(input int unsigned k, input int unsigned p);
    repeat (k) begin
      @(posedge pclk);
      pins.external_trigger_in <= 1'b0;
      repeat (p) @(posedge pclk);
      pins.external_trigger_in <= 1'b1;
      repeat (p - 1) @(posedge pclk);
    end
  endtask : trig_edges
  task automatic set_standby(input logic v);
    pins.standby_in <= v;
  endtask : set_standby
  task automatic set_source(input logic v);
    pins.current_source_select <= v;
  endtask : set_source
  task automatic opto_pulse();
    @(posedge pclk);
    pins.optical_detect <= 1'b1;
    repeat (4) @(posedge pclk);
    pins.optical_detect <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : opto_pulse
endmodule : port_controller_model

// ==== verification/laser_analog_control_port_tb.sv ====
// Self-checking bench for the laser control port
`timescale 1ns/1ns
module laser_analog_control_port_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_t;
  logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                       tec_stable, power_on_lamp, qswitch_trig, rd_err;
  logic                       interlock_closed, trig_sync_out, opto_sync_out;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic [11:0]                diode_current, energy_hold, energy_adc, ext_current_code;
  laser_port_pkg::port_pins_t pins;
  laser_port_pkg::oc_ind_t    ind_oe_n, ind_level;
  int                         fail_count = 0, tests_run = 0, trig_count = 0, n0;
  int                         sync_count = 0, opto_count = 0, s0, o0;
  localparam int unsigned     SETTLE = 20, TMIN = 40, TMAX = 60, LONG = 200, LOCK = 300;
  localparam int unsigned     WARM = 10;
  row_t rows[4] = '{'{8'h00, 32'h1, 1'b0}, '{8'h04, 32'h3e8, 1'b0},
                    '{8'h08, 32'h800, 1'b0}, '{8'h14, 32'h0, 1'b1}};
  laser_analog_control_port #(.SETTLE_CYC(SETTLE), .TOGGLE_MIN_CYC(TMIN), .TOGGLE_MAX_CYC(TMAX),
    .LONG_OFF_CYC(LONG), .LOCKOUT_CYC(LOCK), .WARMUP_CYC(WARM)) laser_analog_control_port_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .tec_stable(tec_stable), .interlock_closed(interlock_closed),
    .energy_adc(energy_adc), .ext_current_code(ext_current_code), .ind_level(ind_level),
    .ind_oe_n(ind_oe_n), .power_on_lamp(power_on_lamp), .diode_current(diode_current),
    .qswitch_trig(qswitch_trig), .trig_sync_out(trig_sync_out), .opto_sync_out(opto_sync_out),
    .energy_hold(energy_hold));
  port_controller_model port_controller_model_inst (
    .ind_oe_n(ind_oe_n), .pclk(pclk), .pins(pins));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (qswitch_trig === 1'b1) trig_count++;
  always @(posedge pclk) if (trig_sync_out === 1'b0) sync_count++;
  always @(posedge pclk) if (opto_sync_out === 1'b0) opto_count++;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, tec_stable, interlock_closed} = 6'h01;
    {energy_adc, ext_current_code} = 24'h7d0000;
    paddr = 8'h00;
    pwdata = 32'h0;
    wait_cyc(20);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("rdata", rows[i].d, rd);
      chk("pslverr", rows[i].e, rd_err);
    end
    wait_cyc(10);
    port_controller_model_inst.power_pulse(10);
    wait_cyc(10);
    chk("lamp", 1'b0, power_on_lamp);
    port_controller_model_inst.power_pulse(50);
    wait_cyc(10);
    chk("lamp", 1'b1, power_on_lamp);
    tec_stable <= 1'b1;
    wait_cyc(6);
    chk("ready_oe_n", 1'b0, ind_oe_n.ready);
    chk("ilk_oe_n", 1'b1, ind_oe_n.interlock_open_indicator);
    // Toggle-length press still inside the start-up lockout
    port_controller_model_inst.power_pulse(50);
    wait_cyc(10);
    chk("lamp", 1'b1, power_on_lamp);
    apb(1'b1, laser_port_pkg::REG_CURRENT, 32'h123);
    apb(1'b1, laser_port_pkg::REG_RATE, 32'h0);
    apb(1'b1, laser_port_pkg::REG_CTRL, 32'h0);
    port_controller_model_inst.emit();
    wait_cyc(6);
    chk("emit_oe_n", 1'b0, ind_oe_n.emission);
    chk("emit_err", 0, port_controller_model_inst.err_count);
    wait_cyc(20);
    chk("current", 12'h123, diode_current);
    port_controller_model_inst.set_standby(1'b0);
    wait_cyc(6);
    chk("current", 12'h0cd, diode_current);
    port_controller_model_inst.set_standby(1'b1);
    energy_adc <= 12'h5a5;
    n0 = trig_count;
    s0 = sync_count;
    port_controller_model_inst.trig_edges(3, 200);
    wait_cyc(10);
    chk("trig_count", n0 + 3, trig_count);
    chk("sync_count", s0 + 3, sync_count);
    chk("energy", 12'h5a5, energy_hold);
    // Edges 40 cycles apart: only the first may fire
    n0 = trig_count;
    port_controller_model_inst.trig_edges(3, 20);
    wait_cyc(10);
    chk("trig_count", n0 + 1, trig_count);
    o0 = opto_count;
    port_controller_model_inst.opto_pulse();
    energy_adc <= 12'h010;
    port_controller_model_inst.opto_pulse();
    wait_cyc(10);
    chk("opto_count", o0 + 1, opto_count);
    n0 = trig_count;
    apb(1'b1, laser_port_pkg::REG_RATE, 32'h20);
    wait_cyc(110);
    chk("trig_count", n0 + 3, trig_count);
    interlock_closed <= 1'b0;
    wait_cyc(6);
    chk("emit_oe_n", 1'b1, ind_oe_n.emission);
    chk("ilk_oe_n", 1'b0, ind_oe_n.interlock_open_indicator);
    ext_current_code <= 12'habc;
    port_controller_model_inst.set_source(1'b0);
    wait_cyc(6);
    interlock_closed <= 1'b1;
    wait_cyc(20);
    chk("current", 12'habc, diode_current);
    port_controller_model_inst.set_source(1'b1);
    wait_cyc(6);
    chk("current", 12'habc, diode_current);
    apb(1'b1, laser_port_pkg::REG_CTRL, 32'h4);
    apb(1'b0, laser_port_pkg::REG_STATUS, 32'h0);
    chk("standby", 1'b1, rd[laser_port_pkg::ST_STANDBY_BIT]);
    port_controller_model_inst.power_pulse(220);
    wait_cyc(10);
    chk("lamp", 1'b0, power_on_lamp);
    presetn <= 1'b0;
    wait_cyc(2);
    chk("ind_oe_n", 3'h7, ind_oe_n);
    chk("ind_level", 3'h0, ind_level);
    presetn <= 1'b1;
    apb(1'b0, laser_port_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, laser_port_pkg::REG_RATE, 32'h0);
    chk("rate", 32'h3e8, rd);
    give_verdict();
  end
endmodule : laser_analog_control_port_tb
